// ==== etx_pkg.sv ====
// Purpose: shared constants for the eight-channel E1 transmit control block
// Assumes: 50 MHz system clock, one line bit per tx_bit_en pulse
// Notes: register map is a plain address/strobe port, byte-wide data
package etx_pkg;
  localparam int NCH = 8;
  localparam int NSEG = 8;
  // register indices (one 8-bit register per address)
  localparam logic [7:0] SEG_BASE = 8'h00;     // ch*8+seg, segment words 0x00..0x3F
  localparam logic [7:0] CTRL_BASE = 8'h40;    // 0x40..0x47 per channel control
  localparam logic [7:0] STAT_BASE = 8'h48;    // 0x48..0x4F per channel alarm status
  localparam logic [7:0] CHG_BASE = 8'h50;     // 0x50..0x57 change status, clear on read
  localparam logic [7:0] IEN_ADDR = 8'h58;     // per channel driver monitor interrupt enable
  // control field positions
  localparam int CTL_HIZ = 0;
  localparam int CTL_LB_LO = 1;
  localparam int CTL_LB_HI = 3;
  localparam int CTL_AONES = 4;
  localparam int CTL_PRBS = 5;
  // status field positions
  localparam int ST_LOS = 0;
  localparam int ST_DRV = 1;
  // segment word layout
  localparam int SEG_SIGN = 7;
  localparam logic [6:0] SEG_FULL = 7'h7F;
  localparam logic [7:0] SEG_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // driver monitor idle limit in line bit periods (tx_bit_en pulses)
  localparam int IDLE_LIMIT = 128;
  localparam logic [7:0] IDLE_MAX = 8'(IDLE_LIMIT);
  // loopback select codes
  localparam logic [2:0] LB_NONE = 3'h0;
  localparam logic [2:0] LB_LOCAL = 3'h1;
  localparam logic [2:0] LB_REMOTE = 3'h2;
  localparam logic [2:0] LB_DIGITAL = 3'h3;
  localparam logic [2:0] LB_DUAL = 3'h4;
  // prbs 2^15-1 seed
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;
endpackage

// ==== etx_chan.sv ====
// Purpose: one channel: data source select, loopback routing, driver monitor
// Assumes: tx_bit_en marks each line bit period
// Notes: all-ones and prbs sources force single rail output
`timescale 1ns/1ps
module etx_chan (
  input wire logic clk_in,              // system clock
  input wire logic nrst_in,             // sync reset, low active
  input wire logic bit_en_in,           // one line bit period
  input wire logic [7:0] ctrl_in,       // channel control register
  input wire logic tx_pos_rail_in,      // system positive rail
  input wire logic tx_neg_rail_in,      // system negative rail
  input wire logic rx_line_pos_in,      // recovered line positive mark
  input wire logic rx_line_neg_in,      // recovered line negative mark
  output logic line_pos_out,            // pulse toward line, positive
  output logic line_neg_out,            // pulse toward line, negative
  output logic rx_pos_rail_out,         // receive rail to system
  output logic rx_neg_rail_out,         // receive rail to system
  output logic drv_alarm_out            // driver failure alarm
);
  logic [14:0] prbs_q, prbs_d;
  logic [7:0] idle_q, idle_d;
  logic alarm_q, alarm_d;
  logic tp_q, tp_d, tn_q, tn_d, rp_q, rp_d, rn_q, rn_d;
  logic [2:0] lb;
  logic src_p, src_n, diag, loop_rx;
  assign lb = ctrl_in[etx_pkg::CTL_LB_HI:etx_pkg::CTL_LB_LO];

  // source and loopback routing
  always_comb begin
    diag = ctrl_in[etx_pkg::CTL_AONES] | ctrl_in[etx_pkg::CTL_PRBS];
    if (ctrl_in[etx_pkg::CTL_AONES]) begin
      src_p = 1'b1;
      src_n = 1'b0;
    end else if (ctrl_in[etx_pkg::CTL_PRBS]) begin
      src_p = prbs_q[14];
      src_n = 1'b0;
    end else begin
      src_p = tx_pos_rail_in;
      src_n = tx_neg_rail_in;
    end
    if ((lb == etx_pkg::LB_REMOTE || lb == etx_pkg::LB_DUAL) && !diag) begin
      tp_d = rx_line_pos_in;
      tn_d = rx_line_neg_in;
    end else begin
      tp_d = src_p;
      tn_d = src_n;
    end
    // local loop feeds tx to rx
    loop_rx = (lb == etx_pkg::LB_LOCAL);
    if (lb == etx_pkg::LB_DIGITAL || lb == etx_pkg::LB_DUAL) begin
      rp_d = src_p;
      rn_d = src_n;
    end else if (loop_rx) begin
      rp_d = tp_q;
      rn_d = tn_q;
    end else begin
      rp_d = rx_line_pos_in;
      rn_d = rx_line_neg_in;
    end
    prbs_d = {prbs_q[13:0], prbs_q[14] ^ prbs_q[13]};
    idle_d = idle_q;
    alarm_d = alarm_q;
    if (tp_q | tn_q) begin
      idle_d = 8'h00;
      alarm_d = 1'b0;
    end else if (idle_q >= etx_pkg::IDLE_MAX) begin
      alarm_d = 1'b1;
    end else begin
      idle_d = idle_q + 8'h01;
    end
    if (!bit_en_in) begin
      tp_d = tp_q;
      tn_d = tn_q;
      rp_d = rp_q;
      rn_d = rn_q;
      prbs_d = prbs_q;
      idle_d = idle_q;
      alarm_d = alarm_q;
    end
  end

  // registers
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      prbs_q <= etx_pkg::PRBS_SEED;
      idle_q <= 8'h00;
      alarm_q <= 1'b0;
      tp_q <= 1'b0;
      tn_q <= 1'b0;
      rp_q <= 1'b0;
      rn_q <= 1'b0;
    end else begin
      prbs_q <= prbs_d;
      idle_q <= idle_d;
      alarm_q <= alarm_d;
      tp_q <= tp_d;
      tn_q <= tn_d;
      rp_q <= rp_d;
      rn_q <= rn_d;
    end
  end

  assign line_pos_out = tp_q;
  assign line_neg_out = tn_q;
  assign rx_pos_rail_out = rp_q;
  assign rx_neg_rail_out = rn_q;
  assign drv_alarm_out = alarm_q;

  idle_alarm_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(alarm_q) |-> $past(idle_q) == etx_pkg::IDLE_MAX)
    else $error("driver alarm rose early");
  // all ones sends no negative mark
  diag_single_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (bit_en_in && ctrl_in[etx_pkg::CTL_AONES]) |=> (tp_q && !tn_q))
    else $error("diagnostic not single rail");
endmodule

// ==== etx_top.sv ====
// Purpose: eight-channel E1 transmit pulse shaper, loopback and driver monitor
// Assumes: register port with one-cycle strobes; read data the next cycle
// Notes: line pair is modelled as a signed 8-bit level per channel plus enable
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module etx_top (
  input wire logic clk_in,                   // 50 MHz clock
  input wire logic nrst_in,                  // sync reset, low active
  input wire logic tx_bit_en_in,             // one line bit period pulse
  input wire logic [7:0] addr_in,            // register address
  input wire logic [7:0] wdata_in,           // write data
  input wire logic wr_in,                    // write strobe
  input wire logic rd_in,                    // read strobe
  output logic [7:0] rdata_out,              // read data, cycle after rd_in
  input wire logic [7:0] tx_pos_rail_in,     // system positive rails
  input wire logic [7:0] tx_neg_rail_in,     // system negative rails
  input wire logic [7:0] rx_line_pos_in,     // recovered line positive marks
  input wire logic [7:0] rx_line_neg_in,     // recovered line negative marks
  input wire logic [7:0] rx_signal_loss_alarm_in, // per channel loss of signal
  output logic [7:0] rx_pos_rail_out,        // receive rails to system
  output logic [7:0] rx_neg_rail_out,        // receive rails to system
  output logic [63:0] tx_line_pair_out,      // signed drive level per channel
  output logic [7:0] tx_line_pair_oe_n_out,  // low while channel drives line
  output logic [7:0] driver_fail_alarm_out,  // per channel driver alarm
  output logic rx_loss_any_out,              // any channel loss of signal
  output logic driver_fail_any_out,          // any channel driver alarm
  output logic irq_n_out                     // driver alarm change interrupt
);
  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [7:0] seg_q [0:63];
  logic [7:0] seg_d [0:63];
  logic [7:0] ctrl_q [0:7];
  logic [7:0] ctrl_d [0:7];
  logic [7:0] chg_q, chg_d, ien_q, ien_d, rdata_q, rdata_d;
  logic [7:0] alarm_prev_q, alarm_prev_d;
  logic [2:0] segidx_q, segidx_d;
  logic [7:0] lpos, lneg;
  logic [7:0] hiz;

  // per channel datapath
  genvar g;
  generate
    for (g = 0; g < etx_pkg::NCH; g++) begin : ch
      logic [7:0] w;
      etx_chan u_chan (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .bit_en_in(tx_bit_en_in),
        .ctrl_in(ctrl_q[g]),
        .tx_pos_rail_in(tx_pos_rail_in[g]),
        .tx_neg_rail_in(tx_neg_rail_in[g]),
        .rx_line_pos_in(rx_line_pos_in[g]),
        .rx_line_neg_in(rx_line_neg_in[g]),
        .line_pos_out(lpos[g]),
        .line_neg_out(lneg[g]),
        .rx_pos_rail_out(rx_pos_rail_out[g]),
        .rx_neg_rail_out(rx_neg_rail_out[g]),
        .drv_alarm_out(driver_fail_alarm_out[g])
      );
      // current segment word of the pulse
      assign w = seg_q[g * 8 + int'(segidx_q)];
      always_comb begin
        if (!(lpos[g] | lneg[g])) begin
          tx_line_pair_out[g * 8 +: 8] = 8'h00;
        end else if (w[etx_pkg::SEG_SIGN] ^ lneg[g]) begin
          tx_line_pair_out[g * 8 +: 8] = 8'(-$signed({1'b0, w[6:0]}));
        end else begin
          tx_line_pair_out[g * 8 +: 8] = {1'b0, w[6:0]};
        end
      end
      assign hiz[g] = ctrl_q[g][etx_pkg::CTL_HIZ];
      assign tx_line_pair_oe_n_out[g] = hiz[g];
    end
  endgenerate

  // ------------------------------------------------------------
  // register writes, reads and interrupt status
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      seg_d[i] = seg_q[i];
    end
    for (int i = 0; i < 8; i++) begin
      ctrl_d[i] = ctrl_q[i];
    end
    ien_d = ien_q;
    rdata_d = 8'h00;
    segidx_d = tx_bit_en_in ? 3'h0 : segidx_q + 3'h1;
    alarm_prev_d = driver_fail_alarm_out;
    chg_d = chg_q;
    if (wr_in) begin
      if (addr_in < etx_pkg::CTRL_BASE) begin
        seg_d[addr_in[5:0]] = wdata_in;
      end else if (addr_in < etx_pkg::STAT_BASE) begin
        ctrl_d[addr_in[2:0]] = wdata_in;
        if (wdata_in[etx_pkg::CTL_LB_HI:etx_pkg::CTL_LB_LO] > etx_pkg::LB_DUAL) begin
          ctrl_d[addr_in[2:0]][etx_pkg::CTL_LB_HI:etx_pkg::CTL_LB_LO] = etx_pkg::LB_NONE;
        end
      end else if (addr_in == etx_pkg::IEN_ADDR) begin
        ien_d = wdata_in;
      end
    end
    if (rd_in) begin
      if (addr_in < etx_pkg::CTRL_BASE) begin
        rdata_d = seg_q[addr_in[5:0]];
      end else if (addr_in < etx_pkg::STAT_BASE) begin
        rdata_d = ctrl_q[addr_in[2:0]];
      end else if (addr_in < etx_pkg::CHG_BASE) begin
        rdata_d[etx_pkg::ST_LOS] = rx_signal_loss_alarm_in[addr_in[2:0]];
        rdata_d[etx_pkg::ST_DRV] = driver_fail_alarm_out[addr_in[2:0]];
      end else if (addr_in < etx_pkg::IEN_ADDR) begin
        rdata_d[etx_pkg::ST_DRV] = chg_q[addr_in[2:0]];
        chg_d[addr_in[2:0]] = 1'b0;
      end else if (addr_in == etx_pkg::IEN_ADDR) begin
        rdata_d = ien_q;
      end
    end
    // set wins over the read clear
    chg_d = chg_d | (driver_fail_alarm_out ^ alarm_prev_q);
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 64; i++) begin
        seg_q[i] <= etx_pkg::SEG_RST;
      end
      for (int i = 0; i < 8; i++) begin
        ctrl_q[i] <= etx_pkg::CTRL_RST;
      end
      ien_q <= 8'h00;
      chg_q <= 8'h00;
      rdata_q <= 8'h00;
      alarm_prev_q <= 8'h00;
      segidx_q <= 3'h0;
    end else begin
      seg_q <= seg_d;
      ctrl_q <= ctrl_d;
      ien_q <= ien_d;
      chg_q <= chg_d;
      rdata_q <= rdata_d;
      alarm_prev_q <= alarm_prev_d;
      segidx_q <= segidx_d;
    end
  end

  assign rdata_out = rdata_q;
  assign irq_n_out = ~|(chg_q & ien_q);
  assign rx_loss_any_out = |rx_signal_loss_alarm_in;
  assign driver_fail_any_out = |driver_fail_alarm_out;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence chg_read_s;
    rd_in && addr_in >= etx_pkg::CHG_BASE && addr_in < etx_pkg::IEN_ADDR;
  endsequence
  irq_on_change_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ($changed(driver_fail_alarm_out[0]) && ien_q[0]) |=> !irq_n_out)
    else $error("interrupt missed alarm change");
  read_clear_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (chg_read_s and (driver_fail_alarm_out == alarm_prev_q)) |=> !chg_q[$past(addr_in[2:0])])
    else $error("change bit not cleared by read");
  hiz_oe_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    tx_line_pair_oe_n_out[0] == ctrl_q[0][etx_pkg::CTL_HIZ])
    else $error("hiz select not applied");
  global_drv_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (driver_fail_any_out == (driver_fail_alarm_out != 8'h00)))
    else $error("global driver alarm wrong");
  lb_legal_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ctrl_q[0][etx_pkg::CTL_LB_HI:etx_pkg::CTL_LB_LO] <= etx_pkg::LB_DUAL)
    else $error("illegal loopback code");
  seg_reset_a: assert property (@(posedge clk_in)
    !nrst_in |=> seg_q[0] == etx_pkg::SEG_RST)
    else $error("segment not cleared by reset");
endmodule

// ==== etx_framer_model.sv ====
// Purpose: framer and line partner for the transmit control block
// Assumes: one line bit every eight clocks, one clock per segment
// Notes: rails and marks are steady levels picked by the bench
`timescale 1ns/1ps
module etx_framer_model (
  input wire logic clk_in, // system clock
  input wire logic nrst_in, // sync reset, low active
  input wire logic [7:0] pos_in, // channels sending positive marks
  input wire logic [7:0] neg_in, // channels sending negative marks
  input wire logic [7:0] rxp_in, // line positive marks
  input wire logic [7:0] rxn_in, // line negative marks
  output logic bit_en_out, // one line bit period
  output logic [7:0] tx_pos_out, // system positive rail
  output logic [7:0] tx_neg_out, // system negative rail
  output logic [7:0] rx_pos_out, // recovered positive mark
  output logic [7:0] rx_neg_out // recovered negative mark
);
  logic [2:0] seg_q;
  // eight clocks a bit so each segment word gets its own clock
  always_ff @(posedge clk_in) begin
    seg_q <= nrst_in ? seg_q + 3'h1 : 3'h0;
  end
  // outputs are combinational so they hold a value from time zero
  assign bit_en_out = nrst_in && (seg_q == 3'h7);
  assign tx_pos_out = pos_in;
  assign tx_neg_out = neg_in;
  assign rx_pos_out = rxp_in;
  assign rx_neg_out = rxn_in;
endmodule

// ==== test_e1_tx_pulse_loopback_monitor.sv ====
// Purpose: self-checking bench for the transmit control block
// Assumes: register reads land one cycle after the strobe
// Notes: only channel 0 raises the interrupt in these runs
`timescale 1ns/1ps
module test_e1_tx_pulse_loopback_monitor;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] pos = 8'h00;
  logic [7:0] neg = 8'h00;
  logic [7:0] rxp = 8'h00;
  logic [7:0] rxn = 8'h00;
  logic [7:0] los = 8'h00;
  logic bit_en, irq_n, los_any, drv_any;
  logic [7:0] rdata, tp, tn, rp, rn, rx_pos, rx_neg, oe_n, alarm;
  logic [63:0] line;
  int failures = 0;
  int cmp_count = 0;
  int bits = 0;
  etx_framer_model etx_framer_model_i (.clk_in(clk_in), .nrst_in(nrst_in), .pos_in(pos), .neg_in(neg),
    .rxp_in(rxp), .rxn_in(rxn), .bit_en_out(bit_en), .tx_pos_out(tp), .tx_neg_out(tn),
    .rx_pos_out(rp), .rx_neg_out(rn));
  etx_top etx_top_i (.clk_in(clk_in), .nrst_in(nrst_in), .tx_bit_en_in(bit_en), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .tx_pos_rail_in(tp),
    .tx_neg_rail_in(tn), .rx_line_pos_in(rp), .rx_line_neg_in(rn), .rx_signal_loss_alarm_in(los),
    .rx_pos_rail_out(rx_pos), .rx_neg_rail_out(rx_neg), .tx_line_pair_out(line),
    .tx_line_pair_oe_n_out(oe_n), .driver_fail_alarm_out(alarm), .rx_loss_any_out(los_any),
    .driver_fail_any_out(drv_any), .irq_n_out(irq_n));
  // 50 MHz clock
  always #10 clk_in = ~clk_in;
  // line bits seen since reset, the yardstick for the idle limit
  always @(posedge clk_in) begin
    if (nrst_in && bit_en === 1'b1) bits <= bits + 1;
  end
  task automatic finish_test;
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask
  // bounded wait on one alarm bit; running out ends the run
  task automatic waitbit(input int ch, input logic v, input int lim);
    int n;
    n = 0;
    while (alarm[ch] !== v) begin
      @(posedge clk_in);
      #1;
      n++;
      if (n > lim) begin
        chk("alarm wait", 8'h01, 8'h00);
        finish_test();
      end
    end
  endtask
  // looks for a drive level anywhere in three bit periods
  task automatic seen(input int ch, input logic [7:0] v, output logic [7:0] hit);
    hit = 8'h00;
    repeat (24) begin
      @(posedge clk_in);
      #1;
      if (line[ch*8 +: 8] === v) hit = 8'h01;
    end
  endtask
  initial begin
    logic [7:0] h;
    logic [7:0] m;
    int b0;
    logic [7:0] wv [4] = '{8'h7F, 8'hFF, 8'h05, 8'h85};
    logic [7:0] ev [4] = '{8'h7F, 8'h81, 8'h05, 8'hFB};
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk("oe_n", 8'h00, oe_n);
    chk("line idle", 8'h00, {7'h00, line !== 64'h0});
    rreg(8'h00, 8'h00);
    rreg(8'h3F, 8'h00);
    wreg(8'h58, 8'h01);
    wreg(8'h60, 8'hA5);
    rreg(8'h60, 8'h00);
    wreg(8'h40, 8'h0A);
    rreg(8'h40, 8'h00);
    wreg(8'h40, 8'h06);
    rreg(8'h40, 8'h06);
    wreg(8'h40, 8'h00);
    // idle line from reset: alarm, interrupt, clear on read
    waitbit(0, 1'b1, 1200);
    chk("idle bits", 8'h01, {7'h00, bits >= 129 && bits <= 131});
    // change bit registers one cycle after the alarm edge
    @(posedge clk_in);
    #1;
    chk("irq_n", 8'h00, {7'h00, irq_n});
    chk("drv any", 8'h01, {7'h00, drv_any});
    rreg(8'h48, 8'h02);
    rreg(8'h50, 8'h02);
    chk("irq_n", 8'h01, {7'h00, irq_n});
    rreg(8'h50, 8'h00);
    // a pulse clears the alarm and counts as a change
    pos <= 8'h01;
    waitbit(0, 1'b0, 40);
    chk("alarms", 8'hFE, alarm);
    repeat (2) @(posedge clk_in);
    #1;
    chk("irq_n", 8'h00, {7'h00, irq_n});
    rreg(8'h50, 8'h02);
    pos <= 8'h00;
    b0 = bits;
    waitbit(0, 1'b1, 1200);
    chk("restart", 8'h01, {7'h00, bits - b0 >= 128 && bits - b0 <= 132});
    pos <= 8'h01;
    waitbit(0, 1'b0, 40);
    // loss of signal on channel 3
    los <= 8'h08;
    repeat (2) @(posedge clk_in);
    #1;
    chk("los any", 8'h01, {7'h00, los_any});
    rreg(8'h4B, 8'h03);
    los <= 8'h00;
    // distinct words must all show within three bit periods
    for (int k = 0; k < 8; k++) wreg(8'(k), 8'(k + 1));
    m = 8'h00;
    repeat (24) begin
      @(posedge clk_in);
      #1;
      if (line[7:0] >= 8'h01 && line[7:0] <= 8'h08) m[line[2:0] - 3'h1] = 1'b1;
    end
    chk("segments", 8'hFF, m);
    // sign and full scale of a positive mark
    for (int j = 0; j < 4; j++) begin
      for (int k = 0; k < 8; k++) wreg(8'(k), wv[j]);
      seen(0, ev[j], h);
      chk("level", 8'h01, h);
    end
    // loopbacks: 1 remote, 2 digital, 3 dual, 4 local with all ones
    for (int k = 0; k < 8; k++) begin
      wreg(8'(8 + k), 8'h40);
      wreg(8'(24 + k), 8'h40);
    end
    pos <= 8'h0D;
    neg <= 8'h02;
    rxp <= 8'h02;
    rxn <= 8'h1C;
    wreg(8'h41, 8'h04);
    wreg(8'h42, 8'h06);
    wreg(8'h43, 8'h08);
    wreg(8'h44, 8'h12);
    repeat (40) @(posedge clk_in);
    #1;
    chk("rx pos", 8'h1E, rx_pos);
    chk("rx neg", 8'h00, rx_neg & 8'hEF);
    seen(1, 8'h40, h);
    chk("remote", 8'h01, h);
    seen(1, 8'hC0, h);
    chk("remote tx", 8'h00, h);
    seen(3, 8'hC0, h);
    chk("dual", 8'h01, h);
    // backup or failed card: host tristates one channel
    // receive termination is swapped off-block before this transmit step
    wreg(8'h45, 8'h01);
    @(posedge clk_in);
    #1;
    chk("oe_n", 8'h20, oe_n);
    rreg(8'h45, 8'h01);
    finish_test();
  end
endmodule
